/* File: hw/qdc_pkg.sv */
// Constants shared by the quad converter serial load control
package qdc_pkg;
    localparam int          CODE_W      = 16;
    localparam int          WORD_LEN    = 18;
    localparam int          SHIFT_LEN   = 19;
    localparam int          ADDR_HI_POS = 17;
    localparam int          ADDR_LO_POS = 16;
    localparam int          CHANNELS    = 4;
    localparam int          SYNC_STAGES = 2;
    localparam logic [15:0] ZERO_CODE   = 16'h0000;
    localparam logic [15:0] HALF_CODE   = 16'h8000;
    localparam logic [1:0]  POR_SETTLE  = 2'h2;
    localparam logic [1:0]  CH_A        = 2'h0;
    localparam logic [1:0]  CH_D        = 2'h3;

    function automatic logic [15:0] qdc_preset_code(input logic half);
        return half ? HALF_CODE : ZERO_CODE;
    endfunction : qdc_preset_code
endpackage : qdc_pkg

/* File: hw/qdc_sync.sv */
// Two-flop synchroniser bank for pins entering the clk domain
`timescale 1ns/1ns
`default_nettype none
module qdc_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // System
    input  wire logic         clk,
    input  wire logic         rstn,
    // Pins and synchronised copies
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] sync
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= RST_VAL;
            sync <= RST_VAL;
        end else begin
            meta <= pin;
            sync <= meta;
        end
    end
endmodule : qdc_sync
`default_nettype wire

/* File: hw/qdc_serial_load.sv */
// Serial load and double-buffered register logic of the quad converter
`timescale 1ns/1ns
`default_nettype none
module qdc_serial_load (
    // System
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // Serial link pins
    input  wire logic                      cs_n,
    input  wire logic                      sclk,
    input  wire logic                      serial_in,
    output logic                           serial_out,
    // Hardware control pins
    input  wire logic                      load_outputs_strobe_n,
    input  wire logic                      preset_n,
    input  wire logic                      preset_half_sel,
    // Register contents
    output logic [qdc_pkg::CODE_W-1:0]     input_a,
    output logic [qdc_pkg::CODE_W-1:0]     input_b,
    output logic [qdc_pkg::CODE_W-1:0]     input_c,
    output logic [qdc_pkg::CODE_W-1:0]     input_d,
    output logic [qdc_pkg::CODE_W-1:0]     dac_a,
    output logic [qdc_pkg::CODE_W-1:0]     dac_b,
    output logic [qdc_pkg::CODE_W-1:0]     dac_c,
    output logic [qdc_pkg::CODE_W-1:0]     dac_d
);
    import qdc_pkg::*;

    logic [5:0]                            pins_q;
    logic                                  cs_n_q;
    logic                                  sclk_q;
    logic                                  sin_q;
    logic                                  ld_n_q;
    logic                                  preset_n_q;
    logic                                  half_q;
    logic                                  sclk_prev;
    logic                                  cs_prev;
    logic                                  sclk_rise;
    logic                                  sclk_fall;
    logic                                  cs_rise;
    logic [SHIFT_LEN-1:0]                  shreg;
    logic [CHANNELS-1:0][CODE_W-1:0]       in_reg;
    logic [CHANNELS-1:0][CODE_W-1:0]       dac_reg;
    logic [1:0]                            por_cnt;
    logic                                  por_fire;
    logic                                  preset_act;
    logic [CODE_W-1:0]                     preset_val;
    logic [1:0]                            word_addr;

    // Idle levels at reset: chip select, strobe and preset inactive, zero select
    // A preset-low reset value would fire a preset with a stale select bit
    qdc_sync #(
        .W       (6),
        .RST_VAL (6'h26)
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .pin  ({cs_n, sclk, serial_in, load_outputs_strobe_n, preset_n, preset_half_sel}),
        .sync (pins_q)
    );

    assign cs_n_q     = pins_q[5];
    assign sclk_q     = pins_q[4];
    assign sin_q      = pins_q[3];
    assign ld_n_q     = pins_q[2];
    assign preset_n_q = pins_q[1];
    assign half_q     = pins_q[0];

    // Edge history of the synchronised link pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_prev <= 1'b0;
            cs_prev   <= 1'b1;
        end else begin
            sclk_prev <= sclk_q;
            cs_prev   <= cs_n_q;
        end
    end

    assign sclk_rise = sclk_q & ~sclk_prev;
    assign sclk_fall = ~sclk_q & sclk_prev;
    assign cs_rise   = cs_n_q & ~cs_prev;

    // Power-on strobe waits until the select pin has crossed the synchroniser
    // Counter parks one past the settle count so the strobe fires only once
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            por_cnt <= 2'h0;
        end else if (por_cnt != POR_SETTLE + 2'h1) begin
            por_cnt <= por_cnt + 2'h1;
        end
    end

    assign por_fire   = (por_cnt == POR_SETTLE);
    assign preset_act = ~preset_n_q | por_fire;
    assign preset_val = qdc_preset_code(half_q);
    assign word_addr  = shreg[ADDR_HI_POS:ADDR_LO_POS];

    // Shift register; preset leaves it alone
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shreg <= '0;
        end else if (sclk_rise && !cs_n_q && preset_n_q) begin
            shreg <= {shreg[SHIFT_LEN-2:0], sin_q};
        end
    end

    // Daisy chain tap changes on the falling edge so the next part samples it cleanly
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serial_out <= 1'b0;
        end else if (sclk_fall) begin
            serial_out <= shreg[SHIFT_LEN-1];
        end
    end

    // Input registers: preset wins over a load in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in_reg <= '0;
        end else if (preset_act) begin
            for (int i = 0; i < CHANNELS; i++) begin
                in_reg[i] <= preset_val;
            end
        end else if (cs_rise) begin
            in_reg[word_addr] <= shreg[CODE_W-1:0];
        end
    end

    // Output registers depend on the strobe level and preset only, never chip select
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dac_reg <= '0;
        end else if (preset_act) begin
            for (int i = 0; i < CHANNELS; i++) begin
                dac_reg[i] <= preset_val;
            end
        end else if (!ld_n_q) begin
            dac_reg <= in_reg;
        end
    end

    assign input_a = in_reg[0];
    assign input_b = in_reg[1];
    assign input_c = in_reg[2];
    assign input_d = in_reg[3];
    assign dac_a   = dac_reg[0];
    assign dac_b   = dac_reg[1];
    assign dac_c   = dac_reg[2];
    assign dac_d   = dac_reg[3];

    // Checks
    a_shift_advance: assert property (@(posedge clk) disable iff (!rstn)
        sclk_rise && !cs_n_q && preset_n_q
        |=> shreg == {$past(shreg[SHIFT_LEN-2:0]), $past(sin_q)})
        else $error("shift register did not advance on serial clock rise");

    a_shift_capture: assert property (@(posedge clk) disable iff (!rstn)
        sclk_rise && !cs_n_q && preset_n_q |=> shreg[0] == $past(sin_q))
        else $error("serial input bit not captured");

    a_shift_hold_cs: assert property (@(posedge clk) disable iff (!rstn)
        cs_n_q ##1 cs_n_q |-> $stable(shreg))
        else $error("shift register moved with chip select high");

    a_load_select: assert property (@(posedge clk) disable iff (!rstn)
        cs_rise && !preset_act
        |=> in_reg[$past(word_addr)] == $past(shreg[CODE_W-1:0]))
        else $error("addressed input register not loaded");

    a_load_others: assert property (@(posedge clk) disable iff (!rstn)
        cs_rise && !preset_act && word_addr != CH_A |=> $stable(in_reg[0]))
        else $error("unaddressed channel A changed");

    a_load_chan_d: assert property (@(posedge clk) disable iff (!rstn)
        cs_rise && !preset_act && word_addr == CH_D
        |=> dac_reg[3] == $past(dac_reg[3]) || !$past(ld_n_q))
        else $error("channel D output changed while latched");

    a_dac_follow: assert property (@(posedge clk) disable iff (!rstn)
        !ld_n_q && !preset_act |=> dac_reg == $past(in_reg))
        else $error("output registers not transparent with strobe low");

    a_dac_hold: assert property (@(posedge clk) disable iff (!rstn)
        ld_n_q && !preset_act ##1 ld_n_q && !preset_act |-> $stable(dac_reg))
        else $error("output registers moved with strobe high");

    a_dac_cs_free: assert property (@(posedge clk) disable iff (!rstn)
        cs_rise && ld_n_q && !preset_act |=> $stable(dac_reg))
        else $error("chip select disturbed output registers");

    a_preset_value: assert property (@(posedge clk) disable iff (!rstn)
        !preset_n_q |=> in_reg[0] == qdc_preset_code($past(half_q))
                        && dac_reg[3] == qdc_preset_code($past(half_q)))
        else $error("preset value not applied");

    a_por_preset: assert property (@(posedge clk) disable iff (!rstn)
        por_fire |=> in_reg[0] == qdc_preset_code($past(half_q))
                     && dac_reg[2] == qdc_preset_code($past(half_q)))
        else $error("power-on preset value not applied");

    a_por_zero: assert property (@(posedge clk)
        !rstn |-> in_reg == '0 && dac_reg == '0)
        else $error("registers not zero at power-on");

    a_sdo_tap: assert property (@(posedge clk) disable iff (!rstn)
        sclk_fall |=> serial_out == $past(shreg[SHIFT_LEN-1]))
        else $error("serial output tap wrong");

    c_word_load: cover property (@(posedge clk) disable iff (!rstn)
        cs_rise && !preset_act && word_addr == CH_D);
    c_transparent: cover property (@(posedge clk) disable iff (!rstn)
        !ld_n_q && cs_rise);
    c_half_preset: cover property (@(posedge clk) disable iff (!rstn)
        !preset_n_q && half_q);
    c_daisy_out: cover property (@(posedge clk) disable iff (!rstn)
        sclk_fall && shreg[SHIFT_LEN-1]);
    c_por_half: cover property (@(posedge clk) disable iff (!rstn)
        por_fire && half_q);
endmodule : qdc_serial_load
`default_nettype wire

/* File: testbench/qdc_host.sv */
// Serial host model driving the converter link
`timescale 1ns/1ns
`default_nettype none
module qdc_host (
    // System
    input  wire logic clk,
    // Serial link
    output logic      cs_n,
    output logic      sclk,
    output logic      serial_in,
    input  wire logic serial_out
);
    logic [39:0] echo;
    initial begin
        cs_n      = 1'b1;
        sclk      = 1'b0;
        serial_in = 1'b0;
        echo      = '0;
    end
    // Sends n bits MSB first; sel low keeps chip select high throughout
    task automatic send(input logic [39:0] bits, input int n, input logic sel);
        cs_n <= ~sel;
        repeat (4) @(posedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= bits[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            echo = {echo[38:0], serial_out};
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        // Released data line shows the inverse, never a held value
        serial_in <= ~serial_in;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : send
endmodule : qdc_host
`default_nettype wire

/* File: testbench/quad_dac_serial_load_control_test.sv */
// Self-checking bench for the quad converter serial load control
`timescale 1ns/1ns
`default_nettype none
module quad_dac_serial_load_control_test;
    import qdc_pkg::*;
    logic        clk;
    logic        rstn;
    logic        cs_n;
    logic        sclk;
    logic        serial_in;
    logic        serial_out;
    logic        strobe_n;
    logic        preset_n;
    logic        half_sel;
    logic [15:0] inp [4];
    logic [15:0] dac [4];
    logic [15:0] exp_in [4];
    logic [15:0] exp_dac [4];
    logic [39:0] v;
    int          mismatches;
    int          num_checks;
    localparam logic [15:0] CODES [4] = '{16'hffff, 16'h0001, 16'h8000, 16'h7ffe};

    qdc_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
                   .serial_out(serial_out));
    qdc_serial_load dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
        .serial_in(serial_in), .serial_out(serial_out), .load_outputs_strobe_n(strobe_n),
        .preset_n(preset_n), .preset_half_sel(half_sel),
        .input_a(inp[0]), .input_b(inp[1]), .input_c(inp[2]), .input_d(inp[3]),
        .dac_a(dac[0]), .dac_b(dac[1]), .dac_c(dac[2]), .dac_d(dac[3]));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [39:0] e, input logic [39:0] got);
        num_checks++;
        if (got !== e) begin
            $display("FAIL %s expected %h seen %h", what, e, got);
            mismatches++;
        end
    endtask : check

    task automatic check_regs(input string what);
        for (int i = 0; i < CHANNELS; i++) begin
            check({what, " input"}, 40'(exp_in[i]), 40'(inp[i]));
            check({what, " dac"}, 40'(exp_dac[i]), 40'(dac[i]));
        end
        $display("Test %s done", what);
    endtask : check_regs

    task automatic preset_all(input logic [15:0] p);
        for (int i = 0; i < CHANNELS; i++) begin
            exp_in[i]  = p;
            exp_dac[i] = p;
        end
    endtask : preset_all

    // Three padded bytes per word, chip select low across all of them
    task automatic write(input logic [1:0] ch, input logic [15:0] code);
        host.send({22'h0, ch, code}, 24, 1'b1);
        exp_in[ch] = code;
        if (!strobe_n) exp_dac[ch] = code;
    endtask : write

    task automatic set_strobe(input logic s);
        strobe_n <= s;
        repeat (4) @(posedge clk);
        if (!s) exp_dac = exp_in;
    endtask : set_strobe

    // Hang guard
    initial begin
        #400000;
        mismatches++;
        wrap_up();
    end

    initial begin
        rstn       = 1'b0;
        strobe_n   = 1'b1;
        preset_n   = 1'b1;
        half_sel   = 1'b1;
        mismatches = 0;
        num_checks = 0;
        repeat (8) @(posedge clk);
        check("reset input_a", 40'h0, 40'(inp[0]));
        check("reset dac_d", 40'h0, 40'(dac[3]));
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        preset_all(HALF_CODE);
        check_regs("power-on preset");
        for (int c = 0; c < CHANNELS; c++) begin
            write(2'(c), CODES[c]);
            check_regs("address decode");
        end
        set_strobe(1'b0);
        check_regs("strobe transparent");
        set_strobe(1'b1);
        write(CH_A, 16'hbeef);
        check_regs("chip select keeps dacs");
        // Clocks with chip select high, then an empty frame reloads the word
        host.send(40'hf_ffff, 18, 1'b0);
        host.send(40'h0, 0, 1'b1);
        check_regs("clocks ignored");
        v = 40'h05_c3a9_6e17;
        host.send(v, 37, 1'b1);
        exp_in[v[17:16]] = v[15:0];
        check("daisy chain", 40'(v[36:19]), 40'(host.echo[17:0]));
        check_regs("long frame");
        half_sel <= 1'b0;
        preset_n <= 1'b0;
        repeat (4) @(posedge clk);
        preset_all(ZERO_CODE);
        check_regs("preset zero");
        half_sel <= 1'b1;
        repeat (4) @(posedge clk);
        preset_all(HALF_CODE);
        check_regs("preset half");
        preset_n <= 1'b1;
        repeat (4) @(posedge clk);
        set_strobe(1'b0);
        write(2'h2, 16'h4c2d);
        check_regs("strobe tied low");
        wrap_up();
    end
endmodule : quad_dac_serial_load_control_test
`default_nettype wire
